// *** core_status_end.sv ***
// core end: status bits, sleep, count/compare timer and interrupt request capture
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module core_status_end
(
  input  wire logic                            ref_clk,       // core clock
  input  wire logic                            nrst,          // sync reset, low active
  core_link_if.device                          link,          // system-facing wires
  input  wire logic [core_sys_pkg::ADDR_W-1:0] addr,          // register address
  input  wire logic [core_sys_pkg::DATA_W-1:0] wdata,         // write data
  input  wire logic                            wr,            // write strobe
  input  wire logic                            rd,            // read strobe
  output logic      [core_sys_pkg::DATA_W-1:0] rdata,         // read data, cycle after rd
  input  wire logic                            exc_reset,     // soft reset exception taken
  input  wire logic                            exc_nmi,       // nmi exception taken
  input  wire logic                            exc_debug,     // debug exception taken
  input  wire logic                            exc_other,     // any other exception taken
  input  wire logic                            exc_return,    // return from exception
  input  wire logic                            wait_exec,     // wait instruction executed
  output logic      [core_sys_pkg::INT_W-1:0]  irq_level,     // synchronised request levels
  output logic                                 irq            // unmasked event pending
);
  import core_sys_pkg::*;

  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] compare;
  logic [EVT_W-1:0]  events;
  logic [EVT_W-1:0]  mask;
  logic [INT_W-1:0]  sync1;
  logic [INT_W-1:0]  sync2;
  logic [INT_W-1:0]  sync3;
  logic [INT_W-1:0]  level;
  logic              timer_match;
  run_type           run_state;
  run_type           next_run_state;

  wire sel_status  = addr == STATUS_OFS;
  wire sel_count   = addr == COUNT_OFS;
  wire sel_compare = addr == COMPARE_OFS;
  wire sel_event   = addr == EVENT_OFS;
  wire sel_mask    = addr == MASK_OFS;
  wire sel_level   = addr == LEVEL_OFS;

  wire wr_status   = wr && sel_status;
  wire wr_compare  = wr && sel_compare;
  wire wr_count    = wr && sel_count;

  // error level entry outranks exception level entry
  wire err_entry   = exc_reset || exc_nmi;
  wire exc_entry   = exc_other && !exc_debug && !err_entry;

  // a change counts only once the second and third stages agree
  wire [INT_W-1:0] next_level = (sync2 == sync3) ? sync3 : level;
  wire [INT_W-1:0] level_rise = next_level & ~level;
  wire             wake       = |(level & mask[INT_W-1:0]);
  wire             next_match = (count == compare) && !wr_compare;
  wire             sleep_set  = (run_state == RUNNING) && (next_run_state == SLEEPING);

  wire [EVT_W-1:0] evt_set = {sleep_set, next_match && !timer_match, level_rise};
  wire [EVT_W-1:0] evt_clr = (wr && sel_event) ? wdata[EVT_W-1:0] : EVT_CLEAR;

  wire [DATA_W-1:0] read_mux =
      sel_status  ? status :
      sel_count   ? count :
      sel_compare ? compare :
      sel_event   ? DATA_W'(events) :
      sel_mask    ? DATA_W'(mask) :
      sel_level   ? DATA_W'(level) : '0;

  always_comb begin
    case (run_state)
      RUNNING:  next_run_state = wait_exec ? SLEEPING : RUNNING;
      SLEEPING: next_run_state = wake ? RUNNING : SLEEPING;
      default:  next_run_state = RUNNING;
    endcase
  end

  // three-stage capture of the asynchronous request lines
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1 <= INT_NONE;
      sync2 <= INT_NONE;
      sync3 <= INT_NONE;
      level <= INT_NONE;
    end else begin
      sync1 <= link.irq_req;
      sync2 <= sync1;
      sync3 <= sync2;
      level <= next_level;
    end
  end

  // status: hardware entries win over a software write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      status                    <= '0;
      status[ERROR_LEVEL_POS]   <= 1'b1;
    end else begin
      if (wr_status) begin
        status[REDUCED_POWER_POS] <= wdata[REDUCED_POWER_POS];
        status[ERROR_LEVEL_POS]   <= wdata[ERROR_LEVEL_POS];
        status[EXC_LEVEL_POS]     <= wdata[EXC_LEVEL_POS];
      end
      if (exc_return && !err_entry && !exc_entry) begin
        if (status[ERROR_LEVEL_POS])
          status[ERROR_LEVEL_POS] <= 1'b0;
        else
          status[EXC_LEVEL_POS]   <= 1'b0;
      end
      if (err_entry)
        status[ERROR_LEVEL_POS]   <= 1'b1;
      if (exc_entry)
        status[EXC_LEVEL_POS]     <= 1'b1;
    end
  end

  // count steps on every edge without a count write; the core clock never really stops here
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count       <= '0;
      compare     <= COMPARE_RST;
      timer_match <= 1'b0;
    end else begin
      count       <= wr_count ? wdata : count + COUNT_STEP;
      if (wr_compare)
        compare   <= wdata;
      timer_match <= next_match || (timer_match && !wr_compare);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_state <= RUNNING;
      events    <= EVT_CLEAR;
      mask      <= EVT_CLEAR;
      rdata     <= '0;
    end else begin
      run_state <= next_run_state;
      events    <= (events & ~evt_clr) | evt_set;
      if (wr && sel_mask)
        mask    <= wdata[EVT_W-1:0];
      rdata     <= rd ? read_mux : '0;
    end
  end

  assign link.error_level_out     = status[ERROR_LEVEL_POS];
  assign link.exception_level_out = status[EXC_LEVEL_POS];
  assign link.reduced_power_out   = status[REDUCED_POWER_POS];
  assign link.sleep_out           = run_state == SLEEPING;
  assign link.timer_match_irq     = timer_match;
  assign irq_level                = level;
  assign irq                      = |(events & mask);
endmodule : core_status_end

// *** core_sys_pkg.sv ***
// shared constants and types for the core status and interrupt signal link
package core_sys_pkg;
  localparam int          DATA_W         = 32;
  localparam int          ADDR_W         = 8;
  localparam int          INT_W          = 6;
  localparam int          SRC_W          = 63;
  localparam int          ENC_MAX        = 63;
  localparam int          EVT_W          = 8;
  // status register field positions
  localparam int          ERROR_LEVEL_POS   = 2;
  localparam int          EXC_LEVEL_POS     = 1;
  localparam int          REDUCED_POWER_POS = 27;
  // register offsets on the software port
  localparam logic [7:0]  STATUS_OFS     = 8'h00;
  localparam logic [7:0]  COUNT_OFS      = 8'h04;
  localparam logic [7:0]  COMPARE_OFS    = 8'h08;
  localparam logic [7:0]  EVENT_OFS      = 8'h0c;
  localparam logic [7:0]  MASK_OFS       = 8'h10;
  localparam logic [7:0]  LEVEL_OFS      = 8'h14;
  localparam logic [7:0]  ROUTE_OFS      = 8'h00;
  localparam logic [7:0]  SYS_STATE_OFS  = 8'h04;
  // event bit layout
  localparam int          EVT_TIMER      = 6;
  localparam int          EVT_SLEEP      = 7;
  localparam int          TIMER_LINE     = 5;
  // reset values and count step
  localparam logic [31:0] COMPARE_RST    = 32'hffffffff;
  localparam logic [31:0] COUNT_STEP     = 32'h00000001;
  localparam logic [7:0]  EVT_CLEAR      = 8'h00;
  localparam logic [5:0]  INT_NONE       = 6'h00;
  typedef enum logic [1:0] {ROUTE_MUX, ROUTE_OR, ROUTE_ENCODE} route_type;
  typedef enum {RUNNING, SLEEPING} run_type;
endpackage : core_sys_pkg

// *** core_link_if.sv ***
// status, sleep, timer and interrupt request wires between core and system glue
`timescale 1ns/1ps
interface core_link_if;
  import core_sys_pkg::*;
  logic             error_level_out;
  logic             exception_level_out;
  logic             reduced_power_out;
  logic             sleep_out;
  logic             timer_match_irq;
  logic [INT_W-1:0] irq_req;
  modport device (output error_level_out, exception_level_out, reduced_power_out, sleep_out,
                  timer_match_irq, input irq_req);
  modport system (input error_level_out, exception_level_out, reduced_power_out, sleep_out,
                  timer_match_irq, output irq_req);
endinterface : core_link_if

// *** system_glue_end.sv ***
// system end: routes peripheral and timer requests onto the six lines, reports core state
`timescale 1ns/1ps
module system_glue_end
(
  input  wire logic                            ref_clk,        // core clock
  input  wire logic                            nrst,           // sync reset, low active
  core_link_if.system                          link,           // core-facing wires
  input  wire logic [core_sys_pkg::ADDR_W-1:0] addr,           // register address
  input  wire logic [core_sys_pkg::DATA_W-1:0] wdata,          // write data
  input  wire logic                            wr,             // write strobe
  input  wire logic                            rd,             // read strobe
  output logic      [core_sys_pkg::DATA_W-1:0] rdata,          // read data, cycle after rd
  input  wire logic [core_sys_pkg::INT_W-1:0]  periph_irq,     // direct peripheral requests
  input  wire logic [core_sys_pkg::SRC_W-1:0]  periph_src,     // sources for encoded mode
  output logic                                 power_down_ok,  // sleeping with reduced power allowed
  output logic                                 error_level,    // core error level copy
  output logic                                 exception_level // core exception level copy
);
  import core_sys_pkg::*;

  route_type         route;
  logic [INT_W-1:0]  drive;
  logic [INT_W-1:0]  encoded;

  // highest numbered active source wins; zero means none pending
  always_comb begin
    encoded = INT_NONE;
    for (int i = 0; i < ENC_MAX; i++) begin
      if (periph_src[i] || (i == ENC_MAX - 1 && link.timer_match_irq))
        encoded = INT_W'(i + 1);
    end
  end

  wire [INT_W-1:0] timer_vec  = {link.timer_match_irq, {(INT_W-1){1'b0}}};
  wire [INT_W-1:0] low_lines  = periph_irq & {1'b0, {(INT_W-1){1'b1}}};
  wire [INT_W-1:0] next_drive =
      (route == ROUTE_MUX)    ? (low_lines | timer_vec) :
      (route == ROUTE_OR)     ? (periph_irq | timer_vec) :
      (route == ROUTE_ENCODE) ? encoded : INT_NONE;

  wire [DATA_W-1:0] state_word = DATA_W'({link.timer_match_irq, link.sleep_out, link.reduced_power_out,
                                          link.error_level_out, link.exception_level_out, drive});
  wire [DATA_W-1:0] read_mux = (addr == ROUTE_OFS)     ? DATA_W'(route) :
                               (addr == SYS_STATE_OFS) ? state_word : '0;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      route           <= ROUTE_MUX;
      drive           <= INT_NONE;
      rdata           <= '0;
      power_down_ok   <= 1'b0;
      error_level     <= 1'b0;
      exception_level <= 1'b0;
    end else begin
      if (wr && addr == ROUTE_OFS)
        route         <= route_type'(wdata[$bits(route_type)-1:0]);
      drive           <= next_drive;
      rdata           <= rd ? read_mux : '0;
      power_down_ok   <= link.sleep_out && link.reduced_power_out;
      error_level     <= link.error_level_out;
      exception_level <= link.exception_level_out;
    end
  end

  assign link.irq_req = drive;
endmodule : system_glue_end

// *** core_status_irq_signals_chk.sv ***
// assertions on the wires between the core end and the system end
`timescale 1ns/1ps
module core_status_irq_signals_chk
(
  input wire logic                           ref_clk,             // core clock
  input wire logic                           nrst,                // sync reset, low active
  input wire logic                           error_level_out,     // error level
  input wire logic                           exception_level_out, // exception level
  input wire logic                           reduced_power_out,   // reduced power allowed
  input wire logic                           sleep_out,           // core sleeping
  input wire logic                           timer_match_irq,     // timer match
  input wire logic [core_sys_pkg::INT_W-1:0] irq_req              // request lines
);
  import core_sys_pkg::*;
  logic [3:0] quiet_cnt;
  // idle cycles of the request lines; wake must trace back to a request
  always_ff @(posedge ref_clk) begin
    if (!nrst || irq_req != '0) quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // reset values are judged at the first edge after release
  sequence reset_release;
    $rose(nrst);
  endsequence
  a_reset_error_level: assert property (reset_release |-> error_level_out)
    else $error("error level low after reset");
  a_reset_exc_clear: assert property (reset_release |-> !exception_level_out)
    else $error("exception level high after reset");
  a_reset_power_clear: assert property (reset_release |-> !reduced_power_out)
    else $error("reduced power high after reset");
  a_reset_sleep_clear: assert property (reset_release |-> !sleep_out)
    else $error("sleep high after reset");
  a_reset_timer_clear: assert property (reset_release |-> !timer_match_irq)
    else $error("timer high after reset");
  a_reset_req_clear: assert property (reset_release |-> irq_req == '0)
    else $error("request lines active after reset");
  a_timer_routed: assert property (timer_match_irq |=> irq_req[TIMER_LINE])
    else $error("timer not routed onto the top request line");
  a_wake_needs_req: assert property ($fell(sleep_out) |-> quiet_cnt < 4'h8)
    else $error("sleep ended without a request");
endmodule : core_status_irq_signals_chk

// *** core_status_irq_signals_tb.sv ***
// self-checking bench: core end and system end joined by the link
`timescale 1ns/1ps
module core_status_irq_signals_tb;
  import core_sys_pkg::*;
  logic              ref_clk, nrst, c_wr, c_rd, g_wr, g_rd, irq, power_down_ok, error_level, exception_level;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, c_rdata, g_rdata;
  logic [INT_W-1:0]  ev, periph_irq, irq_level;
  logic [SRC_W-1:0]  periph_src;
  int                error_cnt, cmp_count;
  core_link_if link ();
  core_status_end u_core_status_end (.ref_clk(ref_clk), .nrst(nrst), .link(link.device), .addr(addr), .wdata(wdata),
    .wr(c_wr), .rd(c_rd), .rdata(c_rdata), .exc_reset(ev[0]), .exc_nmi(ev[1]), .exc_debug(ev[2]), .exc_other(ev[3]),
    .exc_return(ev[4]), .wait_exec(ev[5]), .irq_level(irq_level), .irq(irq));
  system_glue_end u_system_glue_end (.ref_clk(ref_clk), .nrst(nrst), .link(link.system), .addr(addr), .wdata(wdata),
    .wr(g_wr), .rd(g_rd), .rdata(g_rdata), .periph_irq(periph_irq), .periph_src(periph_src),
    .power_down_ok(power_down_ok), .error_level(error_level), .exception_level(exception_level));
  core_status_irq_signals_chk u_core_status_irq_signals_chk (.ref_clk(ref_clk), .nrst(nrst),
    .error_level_out(link.error_level_out), .exception_level_out(link.exception_level_out),
    .reduced_power_out(link.reduced_power_out), .sleep_out(link.sleep_out), .timer_match_irq(link.timer_match_irq),
    .irq_req(link.irq_req));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // addr and wdata are shared; only the strobe picks the end
  task automatic wreg(input bit g, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    {c_wr, g_wr} <= {!g, g};
    @(posedge ref_clk);
    {c_wr, g_wr} <= 2'b00;
    #1;
  endtask : wreg
  task automatic rreg(input bit g, input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    addr <= a;
    {c_rd, g_rd} <= {!g, g};
    @(posedge ref_clk);
    {c_rd, g_rd} <= 2'b00;
    #1;
    check(nm, g ? g_rdata : c_rdata, exp);
  endtask : rreg
  // ev: 0 reset, 1 nmi, 2 debug, 3 other, 4 return, 5 wait
  task automatic pulse(input int k);
    @(posedge ref_clk);
    ev[k] <= 1'b1;
    @(posedge ref_clk);
    ev <= '0;
    #1;
  endtask : pulse
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  task automatic t_reset;
    check("error out", link.error_level_out, 1'b1);
    rreg(0, STATUS_OFS, 32'h4, "status");
    rreg(0, COMPARE_OFS, COMPARE_RST, "compare");
    rreg(0, 8'h40, 32'h0, "unmapped");
    wreg(1, SYS_STATE_OFS, 32'hffffffff);
    rreg(1, SYS_STATE_OFS, 32'h80, "state ro");
    check("error copy", error_level, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_exc;
    logic [1:0] exp [4] = '{2'b10, 2'b10, 2'b00, 2'b01};
    pulse(4);
    check("error cleared", link.error_level_out, 1'b0);
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      check("levels", {link.error_level_out, link.exception_level_out}, exp[k]);
      pulse(4);
      check("returned", {link.error_level_out, link.exception_level_out}, 2'b00);
    end
    wreg(0, STATUS_OFS, 32'h08000006);
    check("sw bits", {link.reduced_power_out, link.error_level_out, link.exception_level_out}, 3'b111);
    rreg(0, STATUS_OFS, 32'h08000006, "status rw");
    check("exc copy", exception_level, 1'b1);
    wreg(0, STATUS_OFS, 32'h08000000);
    $display("test exceptions done");
  endtask : t_exc
  task automatic t_sleep;
    wreg(0, MASK_OFS, 32'h01);
    pulse(5);
    check("sleep", link.sleep_out, 1'b1);
    cycles(8);
    check("asleep", link.sleep_out, 1'b1);
    check("power down", power_down_ok, 1'b1);
    rreg(0, EVENT_OFS, 32'h80, "sleep event");
    wreg(0, EVENT_OFS, 32'h80);
    check("irq low", irq, 1'b0);
    @(posedge ref_clk);
    periph_irq <= 6'h01;
    for (int i = 0; i < 12 && link.sleep_out; i++) cycles(1);
    check("woken", link.sleep_out, 1'b0);
    check("level", irq_level, 6'h01);
    check("irq", irq, 1'b1);
    wreg(0, MASK_OFS, 32'h00);
    cycles(1);
    check("masked", irq, 1'b0);
    @(posedge ref_clk);
    periph_irq <= 6'h00;
    wreg(0, EVENT_OFS, 32'hff);
    rreg(0, EVENT_OFS, 32'h0, "events cleared");
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_timer;
    wreg(0, COMPARE_OFS, 32'h14);
    wreg(0, COUNT_OFS, 32'h0);
    check("no match", link.timer_match_irq, 1'b0);
    for (int i = 0; i < 40 && !link.timer_match_irq; i++) cycles(1);
    cycles(6);
    check("match held", link.timer_match_irq, 1'b1);
    check("line five", link.irq_req, 6'h20);
    rreg(0, EVENT_OFS, 32'h60, "timer event");
    @(posedge ref_clk);
    periph_src <= 63'h200;
    wreg(1, ROUTE_OFS, 32'h2);
    cycles(2);
    check("encode timer", link.irq_req, 6'h3f);
    wreg(0, COMPARE_OFS, 32'h0);
    check("match dropped", link.timer_match_irq, 1'b0);
    cycles(2);
    check("encode src", link.irq_req, 6'h0a);
    @(posedge ref_clk);
    periph_irq <= 6'h21;
    wreg(1, ROUTE_OFS, 32'h1);
    cycles(2);
    check("or route", link.irq_req, 6'h21);
    wreg(1, ROUTE_OFS, 32'h3);
    rreg(1, ROUTE_OFS, 32'h3, "route read");
    check("no route", link.irq_req, 6'h00);
    wreg(1, ROUTE_OFS, 32'h0);
    cycles(2);
    check("mux route", link.irq_req, 6'h01);
    $display("test timer done");
  endtask : t_timer
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    {nrst, c_wr, c_rd, g_wr, g_rd} = 5'h00;
    {addr, wdata, ev, periph_irq, periph_src} = '0;
    {error_cnt, cmp_count} = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_exc();
    t_sleep();
    t_timer();
    complete_run();
  end
  // all tests need well under a thousand cycles
  initial begin
    #80000;
    error_cnt++;
    complete_run();
  end
endmodule : core_status_irq_signals_tb
